// *** core/ocdc_pkg.sv ***
// Package: register map, field positions and codes of the clock control
package ocdc_pkg;

  // ==========================================================
  // Bus widths, divider width and watchdog consumer count
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int DIV_W = 10;
  localparam int WDOG_USERS = 3;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_UNLOCK = 8'h00;
  localparam logic [7:0] OFS_CTL_ONE = 8'h01;
  localparam logic [7:0] OFS_CTL_TWO = 8'h02;
  localparam logic [7:0] OFS_CTL_FIVE = 8'h05;
  localparam logic [7:0] OFS_TUNE_LOW = 8'h06;
  localparam logic [7:0] OFS_TUNE_HIGH = 8'h07;
  localparam logic [7:0] OFS_CONV_LOW = 8'h08;
  localparam logic [7:0] OFS_CONV_HIGH = 8'h09;
  localparam logic [7:0] OFS_DIV_LOW = 8'h0A;
  localparam logic [7:0] OFS_DIV_HIGH = 8'h0B;

  // ==========================================================
  // Unlock sequence values and status bit
  localparam logic [7:0] UNLOCK_KEY_FIRST = 8'hE7;
  localparam logic [7:0] UNLOCK_KEY_SECOND = 8'h18;
  localparam int BIT_UNLOCKED = 0;

  // ==========================================================
  // Control register one fields
  localparam int BIT_SLOW_XTAL_EN = 0;
  localparam int BIT_RC_OSC_EN = 1;
  localparam int BIT_PCLK_SEL_LO = 2;
  localparam int BIT_PCLK_SEL_HI = 3;
  localparam int BIT_RC_OSC_RDY = 4;

  // Control register two fields
  localparam int BIT_FAST_XTAL_EN = 0;
  localparam int BIT_BAND_LO = 1;
  localparam int BIT_BAND_HI = 2;
  localparam int BIT_FAST_XTAL_RDY = 4;

  // Control register five fields
  localparam int BIT_TUNED_OSC_EN = 0;
  localparam int BIT_LOCK_LOOP_EN = 1;
  localparam int BIT_SEED_SEL = 2;
  localparam int BIT_LOCK_RDY = 4;
  localparam int BIT_LOCK_LOST = 5;
  localparam int BIT_FAST_DONE = 6;

  // ==========================================================
  // Band codes for the fast crystal gain
  localparam logic [1:0] BAND_LOW = 2'h0;     // 1 to 8 MHz
  localparam logic [1:0] BAND_MEDIUM = 2'h1;  // above 8 up to 16 MHz
  localparam logic [1:0] BAND_MAXIMUM = 2'h2; // above 16 up to 24 MHz
  localparam logic [1:0] BAND_RESERVED = 2'h3;

  // Peripheral clock source codes
  localparam logic [1:0] PCLK_RC = 2'h0;
  localparam logic [1:0] PCLK_SLOW_XTAL = 2'h1;
  localparam logic [1:0] PCLK_EXT = 2'h2;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_TUNE_LOW = 8'h00;
  localparam logic [7:0] RST_TUNE_HIGH = 8'h00;
  localparam logic [9:0] RST_DIVIDER = 10'h000;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // Unlock tracker states
  typedef enum logic [1:0] {
    UNL_IDLE,
    UNL_FIRST,
    UNL_OPEN
  } ocdc_unl_state_t;

endpackage

// *** core/ocdc_sync.sv ***
// Two-stage synchroniser for a bundle of asynchronous status levels
`timescale 1ns/1ps
`default_nettype none
module ocdc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,                // System clock
  input wire logic rst_n,              // Async reset, active low
  input wire logic [WIDTH-1:0] d_in,   // Asynchronous levels
  output logic [WIDTH-1:0] q_out       // Synchronised levels
);

  // ==========================================================
  // One pair of flops per bit; first stage feeds only the second
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_r;
      logic sync_r;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
        end else begin
          meta_r <= d_in[i];
          sync_r <= meta_r;
        end
      end
      assign q_out[i] = sync_r;
    end
  endgenerate

endmodule
`default_nettype wire

// *** core/ocdc_top.sv ***
// Oscillator enable and tuned-oscillator lock control, top level
//
// Operation
// - Band field selects low, medium, maximum gain
// - Reset clears fast crystal enable
// - Fast crystal ready clear when disabled
// - Reset clears slow crystal enable
// - Reset sets RC enable; clear stops it
// - Reset selects RC as peripheral clock
// - Watchdog oscillator runs whenever any consumer needs
// - Reset sets tuned oscillator enable
// - Loop off runs free, on locks
// - Lock target is peripheral clock times divider
// - Lock ready set after convergence completes
// - Converged words readable in two registers
// - Seed select one uses software tune words
// - Low tune word buffered until high written
// - High write with seed select one applies both words together
// - Divider high write, seed zero: fast lock
// - Divider high write, seed one: linear lock
// - Setting loop enable starts linear lock
// - Control register writes need ordered E7h then 18h unlock
// - Feedback divider is ten bits wide
// - Loss sets lost, clears ready; disable clears
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module ocdc_top (
  input wire logic clk,                             // System clock 200 MHz
  input wire logic rst_n,                           // Async reset, active low
  input wire logic [ocdc_pkg::ADDR_W-1:0] addr,     // Register address
  input wire logic [ocdc_pkg::DATA_W-1:0] wdata,    // Write data
  input wire logic wr_en,                           // Write strobe
  input wire logic rd_en,                           // Read strobe
  output logic [ocdc_pkg::DATA_W-1:0] rdata,        // Read data, next cycle
  input wire logic fast_xtal_stable,                // Analog: crystal stable
  input wire logic rc_osc_stable,                   // Analog: RC stable
  input wire logic lock_achieved,                   // Loop: lock reached
  input wire logic lock_lost,                       // Loop: lock lost
  input wire logic fast_lock_done,                  // Loop: fast algo done
  input wire logic [7:0] converged_low,             // Loop: low word
  input wire logic [7:0] converged_high,            // Loop: high word
  input wire logic [ocdc_pkg::WDOG_USERS-1:0] wdog_need, // Consumers
  output logic fast_xtal_enable,                    // Fast crystal on
  output logic [1:0] fast_xtal_band_select,         // Gain band
  output logic slow_xtal_enable,                    // Slow crystal on
  output logic rc_osc_enable,                       // RC oscillator on
  output logic [1:0] pclk_source,                   // Peripheral clock mux
  output logic watchdog_osc_enable,                 // Watchdog osc on
  output logic tuned_osc_enable,                    // Tuned osc on
  output logic lock_loop_enable,                    // Lock loop on
  output logic [ocdc_pkg::DIV_W-1:0] lock_divider,  // Feedback divider
  output logic lock_start_fast,                     // Pulse: fast algo
  output logic lock_start_linear,                   // Pulse: linear algo
  output logic seed_from_software,                  // Use applied words
  output logic [7:0] tune_apply_low,                // Applied low word
  output logic [7:0] tune_apply_high                // Applied high word
);
  import ocdc_pkg::*;

  // ==========================================================
  // Synchronised status levels from the analog side and the lock loop
  localparam int N_SYNC = 5;
  logic [N_SYNC-1:0] async_levels;
  logic [N_SYNC-1:0] sync_levels;
  logic fx_stable_s;
  logic rc_stable_s;
  logic achieved_s;
  logic lost_s;
  logic done_s;

  assign async_levels = {fast_lock_done, lock_lost, lock_achieved,
                         rc_osc_stable, fast_xtal_stable};

  ocdc_sync #(.WIDTH(N_SYNC)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d_in(async_levels),
    .q_out(sync_levels)
  );

  assign fx_stable_s = sync_levels[0];
  assign rc_stable_s = sync_levels[1];
  assign achieved_s = sync_levels[2];
  assign lost_s = sync_levels[3];
  assign done_s = sync_levels[4];

  // ==========================================================
  // Address decode
  logic wr_unlock;
  logic wr_one;
  logic wr_two;
  logic wr_five;
  logic wr_tlow;
  logic wr_thigh;
  logic wr_dlow;
  logic wr_dhigh;
  logic unlocked;

  always_comb begin
    wr_unlock = wr_en && (addr == OFS_UNLOCK);
    // Locked controls ignore writes silently
    wr_one = wr_en && unlocked && (addr == OFS_CTL_ONE);
    wr_two = wr_en && unlocked && (addr == OFS_CTL_TWO);
    wr_five = wr_en && unlocked && (addr == OFS_CTL_FIVE);
    wr_tlow = wr_en && (addr == OFS_TUNE_LOW);
    wr_thigh = wr_en && (addr == OFS_TUNE_HIGH);
    wr_dlow = wr_en && (addr == OFS_DIV_LOW);
    wr_dhigh = wr_en && (addr == OFS_DIV_HIGH);
  end

  ocdc_unlock u_unlock (
    .clk(clk),
    .rst_n(rst_n),
    .wr_unlock(wr_unlock),
    .wdata(wdata),
    .unlocked(unlocked)
  );

  // ==========================================================
  // Oscillator enable bits
  logic fx_en_r, fx_en_nxt;
  logic [1:0] band_r, band_nxt;
  logic sx_en_r, sx_en_nxt;
  logic rc_en_r, rc_en_nxt;
  logic [1:0] pclk_r, pclk_nxt;

  always_comb begin
    fx_en_nxt = fx_en_r;
    band_nxt = band_r;
    sx_en_nxt = sx_en_r;
    rc_en_nxt = rc_en_r;
    pclk_nxt = pclk_r;
    if (wr_two) begin
      fx_en_nxt = wdata[BIT_FAST_XTAL_EN];
      // Reserved band code is refused; the old gain stays in force
      if (wdata[BIT_BAND_HI:BIT_BAND_LO] != BAND_RESERVED) begin
        band_nxt = wdata[BIT_BAND_HI:BIT_BAND_LO];
      end
    end
    if (wr_one) begin
      sx_en_nxt = wdata[BIT_SLOW_XTAL_EN];
      rc_en_nxt = wdata[BIT_RC_OSC_EN];
      if (wdata[BIT_PCLK_SEL_HI:BIT_PCLK_SEL_LO] != BAND_RESERVED) begin
        pclk_nxt = wdata[BIT_PCLK_SEL_HI:BIT_PCLK_SEL_LO];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fx_en_r <= 1'b0;
      band_r <= BAND_LOW;
      sx_en_r <= 1'b0;
      rc_en_r <= 1'b1;
      pclk_r <= PCLK_RC;
    end else begin
      fx_en_r <= fx_en_nxt;
      band_r <= band_nxt;
      sx_en_r <= sx_en_nxt;
      rc_en_r <= rc_en_nxt;
      pclk_r <= pclk_nxt;
    end
  end

  // Ready flags follow the enable so a stopped oscillator never reads ready
  logic fx_ready;
  logic rc_ready;
  assign fx_ready = fx_en_r && fx_stable_s;
  assign rc_ready = rc_en_r && rc_stable_s;

  // ==========================================================
  // Tuned oscillator and lock loop control
  logic dco_en_r, dco_en_nxt;
  logic fll_en_r, fll_en_nxt;
  logic seed_r, seed_nxt;
  logic [7:0] div_low_r, div_low_nxt;
  logic [1:0] div_high_r, div_high_nxt;
  logic start_fast_r, start_fast_nxt;
  logic start_lin_r, start_lin_nxt;
  logic reset_kick_r;

  always_comb begin
    dco_en_nxt = dco_en_r;
    fll_en_nxt = fll_en_r;
    seed_nxt = seed_r;
    div_low_nxt = div_low_r;
    div_high_nxt = div_high_r;
    start_fast_nxt = 1'b0;
    start_lin_nxt = 1'b0;
    if (wr_five) begin
      dco_en_nxt = wdata[BIT_TUNED_OSC_EN];
      fll_en_nxt = wdata[BIT_LOCK_LOOP_EN];
      seed_nxt = wdata[BIT_SEED_SEL];
      // Rising loop enable always seeds from present words
      if (wdata[BIT_LOCK_LOOP_EN] && !fll_en_r) begin
        start_lin_nxt = 1'b1;
      end
    end
    if (wr_dlow) begin
      div_low_nxt = wdata;
    end
    if (wr_dhigh) begin
      div_high_nxt = wdata[DIV_W-DATA_W-1:0];
      if (seed_r) begin
        start_lin_nxt = 1'b1;
      end else begin
        start_fast_nxt = 1'b1;
      end
    end
    // Fast search is kicked once as reset releases
    if (reset_kick_r) begin
      start_fast_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dco_en_r <= 1'b1;
      fll_en_r <= 1'b0;
      seed_r <= 1'b0;
      div_low_r <= RST_DIVIDER[DATA_W-1:0];
      div_high_r <= RST_DIVIDER[DIV_W-1:DATA_W];
      start_fast_r <= 1'b0;
      start_lin_r <= 1'b0;
      reset_kick_r <= 1'b1;
    end else begin
      dco_en_r <= dco_en_nxt;
      fll_en_r <= fll_en_nxt;
      seed_r <= seed_nxt;
      div_low_r <= div_low_nxt;
      div_high_r <= div_high_nxt;
      start_fast_r <= start_fast_nxt;
      start_lin_r <= start_lin_nxt;
      reset_kick_r <= 1'b0;
    end
  end

  // ==========================================================
  // Tune words: low is buffered, high write commits the pair
  logic [7:0] tlow_buf_r, tlow_buf_nxt;
  logic [7:0] thigh_r, thigh_nxt;
  logic [7:0] app_low_r, app_low_nxt;
  logic [7:0] app_high_r, app_high_nxt;

  always_comb begin
    tlow_buf_nxt = tlow_buf_r;
    thigh_nxt = thigh_r;
    app_low_nxt = app_low_r;
    app_high_nxt = app_high_r;
    if (wr_tlow) begin
      tlow_buf_nxt = wdata;
    end
    if (wr_thigh) begin
      thigh_nxt = wdata;
      // Seed off: registers update but the oscillator is untouched
      if (seed_r) begin
        app_low_nxt = tlow_buf_r;
        app_high_nxt = wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tlow_buf_r <= RST_TUNE_LOW;
      thigh_r <= RST_TUNE_HIGH;
      app_low_r <= RST_TUNE_LOW;
      app_high_r <= RST_TUNE_HIGH;
    end else begin
      tlow_buf_r <= tlow_buf_nxt;
      thigh_r <= thigh_nxt;
      app_low_r <= app_low_nxt;
      app_high_r <= app_high_nxt;
    end
  end

  // ==========================================================
  // Lock status flags; an arriving event beats a clearing disable
  logic rdy_r, rdy_nxt;
  logic lost_r, lost_nxt;
  logic lost_d_r;
  logic lost_rise;

  assign lost_rise = lost_s && !lost_d_r;

  always_comb begin
    rdy_nxt = rdy_r;
    lost_nxt = lost_r;
    if (!fll_en_nxt) begin
      rdy_nxt = 1'b0;
      lost_nxt = 1'b0;
    end
    if (fll_en_r && achieved_s && !lost_s) begin
      rdy_nxt = 1'b1;
    end
    // A fresh lock start clears an old loss report, but a new loss wins
    if (start_fast_r || start_lin_r) begin
      lost_nxt = 1'b0;
    end
    if (fll_en_r && lost_rise) begin
      lost_nxt = 1'b1;
      rdy_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdy_r <= 1'b0;
      lost_r <= 1'b0;
      lost_d_r <= 1'b0;
    end else begin
      rdy_r <= rdy_nxt;
      lost_r <= lost_nxt;
      lost_d_r <= lost_s;
    end
  end

  // ==========================================================
  // Read mux; unmapped addresses return zero
  logic [7:0] rdata_r, rdata_nxt;

  always_comb begin
    rdata_nxt = READ_ZERO;
    if (rd_en) begin
      case (addr)
        OFS_UNLOCK: rdata_nxt[BIT_UNLOCKED] = unlocked;
        OFS_CTL_ONE: begin
          rdata_nxt[BIT_SLOW_XTAL_EN] = sx_en_r;
          rdata_nxt[BIT_RC_OSC_EN] = rc_en_r;
          rdata_nxt[BIT_PCLK_SEL_HI:BIT_PCLK_SEL_LO] = pclk_r;
          rdata_nxt[BIT_RC_OSC_RDY] = rc_ready;
        end
        OFS_CTL_TWO: begin
          rdata_nxt[BIT_FAST_XTAL_EN] = fx_en_r;
          rdata_nxt[BIT_BAND_HI:BIT_BAND_LO] = band_r;
          rdata_nxt[BIT_FAST_XTAL_RDY] = fx_ready;
        end
        OFS_CTL_FIVE: begin
          rdata_nxt[BIT_TUNED_OSC_EN] = dco_en_r;
          rdata_nxt[BIT_LOCK_LOOP_EN] = fll_en_r;
          rdata_nxt[BIT_SEED_SEL] = seed_r;
          rdata_nxt[BIT_LOCK_RDY] = rdy_r;
          rdata_nxt[BIT_LOCK_LOST] = lost_r;
          rdata_nxt[BIT_FAST_DONE] = done_s;
        end
        OFS_TUNE_LOW: rdata_nxt = tlow_buf_r;
        OFS_TUNE_HIGH: rdata_nxt = thigh_r;
        OFS_CONV_LOW: rdata_nxt = converged_low;
        OFS_CONV_HIGH: rdata_nxt = converged_high;
        OFS_DIV_LOW: rdata_nxt = div_low_r;
        OFS_DIV_HIGH: rdata_nxt[DIV_W-DATA_W-1:0] = div_high_r;
        default: rdata_nxt = READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= READ_ZERO;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign rdata = rdata_r;
  assign fast_xtal_enable = fx_en_r;
  assign fast_xtal_band_select = band_r;
  assign slow_xtal_enable = sx_en_r;
  assign rc_osc_enable = rc_en_r;
  assign pclk_source = pclk_r;
  // No software bit: any consumer starts the watchdog oscillator
  assign watchdog_osc_enable = |wdog_need;
  assign tuned_osc_enable = dco_en_r;
  assign lock_loop_enable = fll_en_r;
  assign lock_divider = {div_high_r, div_low_r};
  assign lock_start_fast = start_fast_r;
  assign lock_start_linear = start_lin_r;
  assign seed_from_software = seed_r;
  assign tune_apply_low = app_low_r;
  assign tune_apply_high = app_high_r;

endmodule
`default_nettype wire

// *** core/ocdc_unlock.sv ***
// Unlock sequence tracker for the clock control registers
`timescale 1ns/1ps
`default_nettype none
module ocdc_unlock (
  input wire logic clk,                         // System clock
  input wire logic rst_n,                       // Async reset, active low
  input wire logic wr_unlock,                   // Write to unlock register
  input wire logic [ocdc_pkg::DATA_W-1:0] wdata, // Written byte
  output logic unlocked                         // Writes to controls allowed
);
  import ocdc_pkg::*;

  ocdc_unl_state_t state_r;
  ocdc_unl_state_t state_nxt;

  // ==========================================================
  // Next state: keys must be ordered, other registers may interleave
  always_comb begin
    state_nxt = state_r;
    if (wr_unlock) begin
      case (state_r)
        UNL_IDLE: begin
          if (wdata == UNLOCK_KEY_FIRST) state_nxt = UNL_FIRST;
        end
        UNL_FIRST: begin
          if (wdata == UNLOCK_KEY_SECOND) begin
            state_nxt = UNL_OPEN;
          end else if (wdata != UNLOCK_KEY_FIRST) begin
            state_nxt = UNL_IDLE;
          end
        end
        UNL_OPEN: begin
          // While open the byte is simply loaded; status bit decides
          if (!wdata[BIT_UNLOCKED]) state_nxt = UNL_IDLE;
        end
        default: state_nxt = UNL_IDLE;
      endcase
    end
  end

  // ==========================================================
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= UNL_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign unlocked = (state_r == UNL_OPEN);

endmodule
`default_nettype wire

// *** tb/ocdc_monitor.sv ***
// Checker of the clock control outputs against the register writes
`timescale 1ns/1ps
`default_nettype none
module ocdc_monitor
  import ocdc_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst_n, // Reset, active low
  input wire logic [ADDR_W-1:0] addr, // Register address
  input wire logic [DATA_W-1:0] wdata, // Write data
  input wire logic wr_en, // Write strobe
  input wire logic [WDOG_USERS-1:0] wdog_need, // Watchdog consumers
  input wire logic watchdog_osc_enable, // Watchdog osc on
  input wire logic [1:0] fast_xtal_band_select, // Gain band
  input wire logic lock_loop_enable, // Loop on
  input wire logic [DIV_W-1:0] lock_divider, // Feedback divider
  input wire logic lock_start_fast, // Fast start pulse
  input wire logic lock_start_linear, // Linear start pulse
  input wire logic seed_from_software, // Seed select
  input wire logic [7:0] tune_apply_low, // Applied low word
  input wire logic [7:0] tune_apply_high // Applied high word
);
  logic hi_wr_r;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Seeded high write, delayed one cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_wr_r <= 1'b0;
    end else begin
      hi_wr_r <= wr_en && addr == OFS_TUNE_HIGH && seed_from_software;
    end
  end
  // ==========================================================
  // Properties
  property p_wdog;
    watchdog_osc_enable == (|wdog_need);
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog enable wrong");
  property p_band;
    fast_xtal_band_select != BAND_RESERVED;
  endproperty
  a_band: assert property (p_band) else $error("reserved band");
  property p_div;
    wr_en && addr == OFS_DIV_LOW |=> lock_divider[7:0] == $past(wdata);
  endproperty
  a_div: assert property (p_div) else $error("divider low wrong");
  property p_fast;
    wr_en && addr == OFS_DIV_HIGH && !seed_from_software |=> lock_start_fast;
  endproperty
  a_fast: assert property (p_fast) else $error("no fast start");
  property p_lin;
    wr_en && addr == OFS_DIV_HIGH && seed_from_software |=> lock_start_linear;
  endproperty
  a_lin: assert property (p_lin) else $error("no linear start");
  property p_rise;
    $rose(lock_loop_enable) |-> lock_start_linear;
  endproperty
  a_rise: assert property (p_rise) else $error("enable no start");
  property p_pair;
    $changed(tune_apply_low) |-> hi_wr_r;
  endproperty
  a_pair: assert property (p_pair) else $error("low word leaked");
  property p_apply;
    hi_wr_r |-> tune_apply_high == $past(wdata);
  endproperty
  a_apply: assert property (p_apply) else $error("high not applied");
  property p_hold;
    wr_en && addr == OFS_TUNE_HIGH && !seed_from_software
      |=> $stable({tune_apply_high, tune_apply_low});
  endproperty
  a_hold: assert property (p_hold) else $error("words moved");
  c_fast: cover property (lock_start_fast);
  c_lin: cover property (lock_start_linear);
  c_pair: cover property (hi_wr_r);
endmodule
bind ocdc_top ocdc_monitor mon_u (.*);
`default_nettype wire

// *** tb/ocdc_partner.sv ***
// Behavioural model of the fast crystal, RC oscillator and lock engine
`timescale 1ns/1ps
`default_nettype none
module ocdc_partner #(
  parameter logic [7:0] CONV_LO = 8'hC3, // Converged low word
  parameter logic [7:0] CONV_HI = 8'h5A // Converged high word
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Reset, active low
  input wire logic fast_xtal_enable, // Crystal powered
  input wire logic rc_osc_enable, // RC powered
  input wire logic lock_loop_enable, // Loop running
  input wire logic lose_cmd, // Bench forces a loss of lock
  output logic fast_xtal_stable, // Crystal settled
  output logic rc_osc_stable, // RC settled
  output logic lock_achieved, // Loop locked
  output logic lock_lost, // Loop lost lock
  output logic fast_lock_done, // Fast search over
  output logic [7:0] converged_low, // Loop low word
  output logic [7:0] converged_high // Loop high word
);
  logic [3:0] fx_cnt, rc_cnt, lk_cnt;
  // Start-up counters; a stopped source restarts
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fx_cnt <= 4'h0;
      rc_cnt <= 4'h0;
      lk_cnt <= 4'h0;
    end else begin
      fx_cnt <= fast_xtal_enable ? fx_cnt + {3'h0, fx_cnt != 4'hF} : 4'h0;
      rc_cnt <= rc_osc_enable ? rc_cnt + {3'h0, rc_cnt != 4'hF} : 4'h0;
      lk_cnt <= (lock_loop_enable && !lose_cmd) ?
        lk_cnt + {3'h0, lk_cnt != 4'hF} : 4'h0;
    end
  end
  // Crystal settles slower than the RC; lock comes before fast done
  assign fast_xtal_stable = fx_cnt > 4'h5;
  assign rc_osc_stable = rc_cnt > 4'h2;
  assign lock_achieved = lk_cnt > 4'h7;
  assign lock_lost = lose_cmd;
  assign fast_lock_done = lk_cnt == 4'hF;
  // Unconverged words differ
  assign converged_low = lock_achieved ? CONV_LO : ~CONV_LO;
  assign converged_high = lock_achieved ? CONV_HI : ~CONV_HI;
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the oscillator enable and lock control
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ocdc_pkg::*;
  logic clk, rst_n, wr_en, rd_en, lose_cmd, watchdog_osc_enable;
  logic [7:0] addr, wdata, rdata, rv, converged_low, converged_high;
  logic fast_xtal_stable, rc_osc_stable, lock_achieved, lock_lost;
  logic fast_lock_done, fast_xtal_enable, slow_xtal_enable, rc_osc_enable;
  logic tuned_osc_enable, lock_loop_enable, lock_start_fast;
  logic lock_start_linear, seed_from_software;
  logic [2:0] wdog_need;
  logic [1:0] fast_xtal_band_select, pclk_source;
  logic [9:0] lock_divider;
  logic [7:0] tune_apply_low, tune_apply_high;
  int mismatches, check_count;
  ocdc_top dut_u (.*);
  ocdc_partner #(.CONV_LO(8'hC3), .CONV_HI(8'h5A)) partner_u (.clk, .rst_n,
    .fast_xtal_enable, .rc_osc_enable, .lock_loop_enable, .lose_cmd,
    .fast_xtal_stable, .rc_osc_stable, .lock_achieved, .lock_lost,
    .fast_lock_done, .converged_low, .converged_high);
  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 rv = rdata;
  endtask
  // Bounded poll of one status bit
  task automatic poll(input logic [7:0] a, input int b, input logic e);
    rd(a);
    for (int i = 0; i < 40 && rv[b] !== e; i++) begin
      rd(a);
    end
    chk(rv[b], e);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    repeat (12) @(posedge clk);
    chk({fast_xtal_enable, slow_xtal_enable, rc_osc_enable, pclk_source,
      tuned_osc_enable, lock_loop_enable, seed_from_software}, 8'h24);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 chk(lock_start_fast, 1'b1);
    @(posedge clk);
    #1 chk(lock_start_fast, 1'b0);
    $display("reset test done");
  endtask
  task automatic t_wdog;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      wdog_need <= i[2:0];
      #1 chk(watchdog_osc_enable, i != 0);
    end
    $display("watchdog test done");
  endtask
  task automatic t_unlock;
    wr(OFS_CTL_TWO, 8'h03);
    chk(fast_xtal_enable, 1'b0);
    wr(OFS_UNLOCK, UNLOCK_KEY_FIRST);
    rd(8'h03);
    chk(rv, 8'h00);
    wr(OFS_UNLOCK, UNLOCK_KEY_SECOND);
    rd(OFS_UNLOCK);
    chk(rv[BIT_UNLOCKED], 1'b1);
    for (int b = 0; b < 4; b++) begin
      wr(OFS_CTL_TWO, {5'h0, b[1:0], 1'b1});
      chk(fast_xtal_band_select, b == 3 ? BAND_MAXIMUM : b[1:0]);
    end
    poll(OFS_CTL_TWO, BIT_FAST_XTAL_RDY, 1'b1);
    wr(OFS_CTL_TWO, 8'h10);
    rd(OFS_CTL_TWO);
    chk(rv[BIT_FAST_XTAL_RDY], 1'b0);
    $display("unlock test done");
  endtask
  task automatic t_rc;
    wr(OFS_CTL_ONE, 8'h00);
    chk(rc_osc_enable, 1'b0);
    wr(OFS_CTL_ONE, 8'h03);
    chk({slow_xtal_enable, rc_osc_enable}, 2'b11);
    poll(OFS_CTL_ONE, BIT_RC_OSC_RDY, 1'b1);
    chk(pclk_source, PCLK_RC);
    $display("rc test done");
  endtask
  task automatic t_tune;
    wr(OFS_TUNE_LOW, 8'hAA);
    wr(OFS_TUNE_HIGH, 8'h55);
    chk({tune_apply_high, tune_apply_low}, 16'h0000);
    wr(OFS_CTL_FIVE, 8'h05);
    chk(seed_from_software, 1'b1);
    wr(OFS_TUNE_LOW, 8'h12);
    chk(tune_apply_low, 8'h00);
    wr(OFS_TUNE_HIGH, 8'h34);
    chk({tune_apply_high, tune_apply_low}, 16'h3412);
    $display("tune test done");
  endtask
  task automatic t_lock;
    wr(OFS_DIV_LOW, 8'h34);
    wr(OFS_DIV_HIGH, 8'hFE);
    chk({lock_start_linear, lock_start_fast, lock_divider}, 12'hA34);
    wr(OFS_CTL_FIVE, 8'h01);
    wr(OFS_DIV_HIGH, 8'h01);
    chk({lock_start_linear, lock_start_fast, lock_divider}, 12'h534);
    wr(OFS_CTL_FIVE, 8'h03);
    chk({lock_loop_enable, lock_start_linear}, 2'b11);
    poll(OFS_CTL_FIVE, BIT_LOCK_RDY, 1'b1);
    rd(OFS_CONV_LOW);
    chk(rv, 8'hC3);
    rd(OFS_CONV_HIGH);
    chk(rv, 8'h5A);
    @(posedge clk);
    lose_cmd <= 1'b1;
    poll(OFS_CTL_FIVE, BIT_LOCK_LOST, 1'b1);
    chk(rv[BIT_LOCK_RDY], 1'b0);
    wr(OFS_CTL_FIVE, 8'h01);
    lose_cmd <= 1'b0;
    rd(OFS_CTL_FIVE);
    chk({lock_loop_enable, rv[5:4]}, 3'b000);
    $display("lock test done");
  endtask
  // ==========================================================
  // Clock, main sequence, watchdog and verdict
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wdog_need = 3'h0;
    lose_cmd = 1'b0;
    mismatches = 0;
    check_count = 0;
    t_reset;
    t_wdog;
    t_unlock;
    t_rc;
    t_tune;
    t_lock;
    test_done;
  end
  // About two hundred times the expected run
  initial begin
    #100000;
    mismatches++;
    test_done;
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
endmodule
`default_nettype wire
